// ==== rct_pkg.sv ====
package rct_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ        = 100_000_000;
  localparam longint CLK_KHZ       = CLK_HZ / 1000;
  localparam longint TEST_MIN_MS   = 40;
  localparam longint TEST_MAX_MS   = 1200;
  localparam longint TEST_STEP_MS  = 100;
  localparam longint HOST_PULSE_MS = 100;
  localparam longint HOST_WAIT_MS  = 500;
  localparam longint PWM_FREQ_HZ   = 8000;

  localparam int unsigned TEST_MIN_CYC   = 32'(TEST_MIN_MS * CLK_KHZ);
  localparam int unsigned TEST_MAX_CYC   = 32'(TEST_MAX_MS * CLK_KHZ);
  localparam int unsigned TEST_STEP_CYC  = 32'(TEST_STEP_MS * CLK_KHZ);
  localparam int unsigned HOST_PULSE_CYC = 32'(HOST_PULSE_MS * CLK_KHZ);
  localparam int unsigned HOST_WAIT_CYC  = 32'(HOST_WAIT_MS * CLK_KHZ);
  localparam int unsigned PWM_PERIOD_CYC = 32'(CLK_HZ / PWM_FREQ_HZ);

  // ---------------------------------------------------------------
  // Thresholds in microamperes
  // ---------------------------------------------------------------
  localparam logic [16:0] DC_TRIP_UA    = 17'h01770;
  localparam logic [16:0] DC_RECOVER_UA = 17'h009C4;
  localparam logic [15:0] AC_TRIP_UA    = 16'h61A8;
  localparam logic [15:0] AC_RECOVER_UA = 16'h2710;

  // ---------------------------------------------------------------
  // Duty scale: duty fraction = ua * NUM / DEN
  // ---------------------------------------------------------------
  localparam logic [47:0] PWM_SCALE_NUM = 48'h00000000014D;
  localparam logic [47:0] PWM_SCALE_DEN = 48'h000000989680;

  // ---------------------------------------------------------------
  // Reset values, sensor test sequence and controller request sequence
  // ---------------------------------------------------------------
  localparam logic [15:0] OFFSET_RST = 16'h0000;

  typedef enum logic [1:0] {ST_IDLE, ST_DC_OFF, ST_AC_OFF, ST_OFFSET} rct_test_t;
  typedef enum logic [1:0] {H_IDLE, H_PULSE, H_WAIT} rct_host_t;

endpackage : rct_pkg

// ==== rct_link_if.sv ====
`timescale 1ns/1ps
interface rct_link_if;
  // Sensor side drives
  logic fault_o;
  logic fault_oe;
  logic dc_trip_o;
  logic dc_trip_oe;
  logic ac_trip_o;
  logic ac_trip_oe;
  logic pwm;
  // Controller side drives
  logic test_req_o;
  logic test_req_oe;
  // Resolved wire levels, pull-up when released
  logic fault_line;
  logic dc_trip_line;
  logic ac_trip_line;
  logic test_req_line;

  assign fault_line    = fault_oe ? fault_o : 1'b1;
  assign dc_trip_line  = dc_trip_oe ? dc_trip_o : 1'b1;
  assign ac_trip_line  = ac_trip_oe ? ac_trip_o : 1'b1;
  assign test_req_line = test_req_oe ? test_req_o : 1'b1;

  modport device (
    output fault_o, fault_oe, dc_trip_o, dc_trip_oe, ac_trip_o, ac_trip_oe, pwm,
    input  test_req_line
  );
  modport host (
    output test_req_o, test_req_oe,
    input  fault_line, dc_trip_line, ac_trip_line
  );
endinterface : rct_link_if

// ==== rct_sensor_end.sv ====
`timescale 1ns/1ps
module rct_sensor_end #(
  parameter int unsigned TEST_MIN_CYC   = rct_pkg::TEST_MIN_CYC,
  parameter int unsigned TEST_MAX_CYC   = rct_pkg::TEST_MAX_CYC,
  parameter int unsigned TEST_STEP_CYC  = rct_pkg::TEST_STEP_CYC,
  parameter int unsigned PWM_PERIOD_CYC = rct_pkg::PWM_PERIOD_CYC
) (
  // Clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_sys_rst,
  // Measurement side
  input  wire logic               i_sys_fault,
  input  wire logic               i_meas_valid,
  input  wire logic signed [15:0] i_dc_ua,
  input  wire logic        [15:0] i_ac_ua,
  // Link
  rct_link_if.device              link,
  // Status
  output logic                    o_test_active,
  output logic             [15:0] o_offset_ua
);
  import rct_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic test_meta_reg;
  logic test_sync_reg;
  logic fault_meta_reg;
  logic fault_sync_reg;

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      test_meta_reg  <= 1'b1;
      test_sync_reg  <= 1'b1;
      fault_meta_reg <= 1'b0;
      fault_sync_reg <= 1'b0;
    end
    else
    begin
      test_meta_reg  <= link.test_req_line;
      test_sync_reg  <= test_meta_reg;
      fault_meta_reg <= i_sys_fault;
      fault_sync_reg <= fault_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Test request timing and test sequence
  // ---------------------------------------------------------------
  rct_test_t   st_reg;
  rct_test_t   st_next;
  logic        test_prev_reg;
  logic [31:0] low_cnt_reg;
  logic [31:0] low_cnt_next;
  logic [31:0] step_cnt_reg;
  logic [31:0] step_cnt_next;
  logic [15:0] offset_reg;
  logic [15:0] offset_next;
  logic        pulse_ok;

  always_comb
  begin
    st_next       = st_reg;
    step_cnt_next = step_cnt_reg;
    offset_next   = offset_reg;
    low_cnt_next  = low_cnt_reg;
    // Low time saturates just above the longest legal pulse
    if (!test_sync_reg)
    begin
      if (low_cnt_reg <= TEST_MAX_CYC)
        low_cnt_next = low_cnt_reg + 32'h00000001;
    end
    else
      low_cnt_next = 32'h00000000;
    pulse_ok = !test_prev_reg && test_sync_reg &&
               (low_cnt_reg >= TEST_MIN_CYC) && (low_cnt_reg <= TEST_MAX_CYC);
    unique case (st_reg)
      ST_IDLE:
      begin
        if (pulse_ok)
        begin
          st_next       = ST_DC_OFF;
          step_cnt_next = 32'h00000000;
        end
      end
      ST_DC_OFF, ST_AC_OFF, ST_OFFSET:
      begin
        if (st_reg == ST_OFFSET && i_meas_valid)
          offset_next = i_dc_ua;
        if (step_cnt_reg == TEST_STEP_CYC - 1)
        begin
          step_cnt_next = 32'h00000000;
          unique case (st_reg)
            ST_DC_OFF: st_next = ST_AC_OFF;
            ST_AC_OFF: st_next = ST_OFFSET;
            default:   st_next = ST_IDLE;
          endcase
        end
        else
          step_cnt_next = step_cnt_reg + 32'h00000001;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_reg        <= ST_IDLE;
      test_prev_reg <= 1'b1;
      low_cnt_reg   <= 32'h00000000;
      step_cnt_reg  <= 32'h00000000;
      offset_reg    <= OFFSET_RST;
    end
    else
    begin
      st_reg        <= st_next;
      test_prev_reg <= test_sync_reg;
      low_cnt_reg   <= low_cnt_next;
      step_cnt_reg  <= step_cnt_next;
      offset_reg    <= offset_next;
    end
  end

  // ---------------------------------------------------------------
  // Trip decisions with hysteresis
  // ---------------------------------------------------------------
  logic        dc_trip_reg;
  logic        dc_trip_next;
  logic        ac_trip_reg;
  logic        ac_trip_next;
  logic [16:0] dc_corr;
  logic [16:0] dc_abs;

  always_comb
  begin
    dc_corr      = 17'({i_dc_ua[15], i_dc_ua} - {offset_reg[15], offset_reg});
    dc_abs       = dc_corr[16] ? 17'(-dc_corr) : dc_corr;
    dc_trip_next = dc_trip_reg;
    ac_trip_next = ac_trip_reg;
    if (i_meas_valid)
    begin
      if (!dc_trip_reg && dc_abs >= DC_TRIP_UA)
        dc_trip_next = 1'b1;
      else if (dc_trip_reg && dc_abs < DC_RECOVER_UA)
        dc_trip_next = 1'b0;
      if (!ac_trip_reg && i_ac_ua >= AC_TRIP_UA)
        ac_trip_next = 1'b1;
      else if (ac_trip_reg && i_ac_ua < AC_RECOVER_UA)
        ac_trip_next = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Duty-cycle monitor output
  // ---------------------------------------------------------------
  logic [31:0] pwm_cnt_reg;
  logic [31:0] pwm_cnt_next;
  logic [31:0] pwm_hi_reg;
  logic [31:0] pwm_hi_next;
  logic [47:0] pwm_prod;
  logic [47:0] pwm_calc;

  always_comb
  begin
    pwm_prod     = 48'(dc_abs) * 48'(PWM_PERIOD_CYC) * PWM_SCALE_NUM;
    pwm_calc     = pwm_prod / PWM_SCALE_DEN;
    pwm_hi_next  = pwm_hi_reg;
    pwm_cnt_next = pwm_cnt_reg + 32'h00000001;
    if (pwm_cnt_reg == PWM_PERIOD_CYC - 1)
    begin
      pwm_cnt_next = 32'h00000000;
      pwm_hi_next  = (pwm_calc > 48'(PWM_PERIOD_CYC)) ? PWM_PERIOD_CYC : pwm_calc[31:0];
    end
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  logic fault_oe_next;
  logic dc_oe_next;
  logic ac_oe_next;
  logic pwm_next;

  always_comb
  begin
    fault_oe_next = !fault_sync_reg;
    ac_oe_next    = !(fault_sync_reg || ac_trip_next ||
                      st_reg == ST_AC_OFF);
    dc_oe_next    = ac_oe_next && !(dc_trip_next ||
                      st_reg == ST_DC_OFF);
    pwm_next      = pwm_cnt_next < pwm_hi_next;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      dc_trip_reg     <= 1'b0;
      ac_trip_reg     <= 1'b0;
      pwm_cnt_reg     <= 32'h00000000;
      pwm_hi_reg      <= 32'h00000000;
      link.fault_o    <= 1'b0;
      link.fault_oe   <= 1'b0;
      link.dc_trip_o  <= 1'b0;
      link.dc_trip_oe <= 1'b0;
      link.ac_trip_o  <= 1'b0;
      link.ac_trip_oe <= 1'b0;
      link.pwm        <= 1'b0;
      o_test_active   <= 1'b0;
      o_offset_ua     <= OFFSET_RST;
    end
    else
    begin
      dc_trip_reg     <= dc_trip_next;
      ac_trip_reg     <= ac_trip_next;
      pwm_cnt_reg     <= pwm_cnt_next;
      pwm_hi_reg      <= pwm_hi_next;
      link.fault_o    <= 1'b0;
      link.fault_oe   <= fault_oe_next;
      link.dc_trip_o  <= 1'b0;
      link.dc_trip_oe <= dc_oe_next;
      link.ac_trip_o  <= 1'b0;
      link.ac_trip_oe <= ac_oe_next;
      link.pwm        <= pwm_next;
      o_test_active   <= st_next != ST_IDLE;
      o_offset_ua     <= offset_next;
    end
  end

endmodule : rct_sensor_end

// ==== rct_ctrl_end.sv ====
`timescale 1ns/1ps
module rct_ctrl_end #(
  parameter int unsigned PULSE_CYC = rct_pkg::HOST_PULSE_CYC,
  parameter int unsigned WAIT_CYC  = rct_pkg::HOST_WAIT_CYC
) (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_sys_rst,
  // User side
  input  wire logic i_test_start,
  output logic      o_relay_on,
  output logic      o_error,
  output logic      o_dc_trip,
  output logic      o_ac_trip,
  output logic      o_test_busy,
  // Link
  rct_link_if.host  link
);
  import rct_pkg::*;

  // ---------------------------------------------------------------
  // Line synchronisers: {fault, ac, dc}, high means released
  // ---------------------------------------------------------------
  logic [2:0] line_meta_reg;
  logic [2:0] line_sync_reg;

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      line_meta_reg <= 3'h7;
      line_sync_reg <= 3'h7;
    end
    else
    begin
      line_meta_reg <= {link.fault_line, link.ac_trip_line, link.dc_trip_line};
      line_sync_reg <= line_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Self-test request sequence
  // ---------------------------------------------------------------
  rct_host_t   st_reg;
  rct_host_t   st_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic        pending_reg;
  logic        pending_next;
  logic        illegal;

  always_comb
  begin
    st_next      = st_reg;
    cnt_next     = cnt_reg + 32'h00000001;
    pending_next = pending_reg || i_test_start;
    unique case (st_reg)
      H_IDLE:
      begin
        cnt_next = 32'h00000000;
        if (pending_reg)
        begin
          st_next      = H_PULSE;
          pending_next = i_test_start;
        end
      end
      H_PULSE:
        if (cnt_reg == PULSE_CYC - 1)
        begin
          st_next  = H_WAIT;
          cnt_next = 32'h00000000;
        end
      H_WAIT:
        if (cnt_reg == WAIT_CYC - 1)
          st_next = H_IDLE;
    endcase
    illegal = line_sync_reg != 3'h0 && line_sync_reg != 3'h1 &&
              line_sync_reg != 3'h3 && line_sync_reg != 3'h7;
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_reg           <= H_IDLE;
      cnt_reg          <= 32'h00000000;
      pending_reg      <= 1'b1;
      link.test_req_o  <= 1'b0;
      link.test_req_oe <= 1'b0;
      o_relay_on       <= 1'b0;
      o_error          <= 1'b0;
      o_dc_trip        <= 1'b0;
      o_ac_trip        <= 1'b0;
      o_test_busy      <= 1'b0;
    end
    else
    begin
      st_reg           <= st_next;
      cnt_reg          <= cnt_next;
      pending_reg      <= pending_next;
      link.test_req_o  <= 1'b0;
      link.test_req_oe <= st_next == H_PULSE;
      o_relay_on       <= st_next == H_IDLE && line_sync_reg == 3'h0;
      o_error          <= illegal || line_sync_reg[2];
      o_dc_trip        <= line_sync_reg[0];
      o_ac_trip        <= line_sync_reg[1];
      o_test_busy      <= st_next != H_IDLE;
    end
  end

endmodule : rct_ctrl_end

// ==== rct_link_chk.sv ====
`timescale 1ns/1ps
module rct_link_chk #(
  parameter int unsigned PWM_PERIOD_CYC = 125,
  parameter int unsigned PULSE_CYC      = 100
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_sys_rst,
  // Sensor side
  input wire logic fault_o,
  input wire logic fault_oe,
  input wire logic dc_trip_o,
  input wire logic dc_trip_oe,
  input wire logic ac_trip_o,
  input wire logic ac_trip_oe,
  input wire logic pwm,
  // Controller side and lines
  input wire logic test_req_oe,
  input wire logic fault_line,
  input wire logic dc_trip_line,
  input wire logic ac_trip_line,
  input wire logic test_req_line
);
  logic [31:0] gap_reg;
  logic [31:0] low_reg;
  logic [31:0] req_reg;
  logic        seen_reg;

  // ---------------------------------------------------------------
  // Helper counters
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      gap_reg  <= 32'h0;
      low_reg  <= 32'h0;
      req_reg  <= 32'h0;
      seen_reg <= 1'b0;
    end
    else
    begin
      gap_reg  <= $rose(pwm) ? 32'h0 : gap_reg + 32'h1;
      seen_reg <= seen_reg | $rose(pwm);
      low_reg  <= test_req_line ? 32'h0 : low_reg + 32'h1;
      req_reg  <= test_req_oe ? req_reg + 32'h1 : 32'h0;
    end
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_sys_rst);

  // ---------------------------------------------------------------
  // Line rules
  // ---------------------------------------------------------------
  chk_open_drain: assert property (!fault_o && !dc_trip_o && !ac_trip_o)
    else $error("open-drain data not low");
  chk_fault_trips: assert property (!fault_oe |-> !dc_trip_oe && !ac_trip_oe)
    else $error("trip line held low with fault line released");
  chk_ac_forces_dc: assert property (!ac_trip_oe |-> !dc_trip_oe)
    else $error("dc line held low with ac line released");
  chk_legal_state: assert property ({fault_line, ac_trip_line, dc_trip_line} inside
    {3'h0, 3'h1, 3'h3, 3'h7})
    else $error("illegal line combination");
  chk_pwm_period: assert property ($rose(pwm) && seen_reg |->
    (gap_reg + 32'h1) % PWM_PERIOD_CYC == 0)
    else $error("duty output rise off the period grid");
  chk_test_dc_off: assert property ($rose(test_req_line) && low_reg >= 42 && low_reg <= 1198
    && fault_oe && dc_trip_oe && ac_trip_oe |-> ##[2:8] (!dc_trip_oe && ac_trip_oe))
    else $error("test did not release dc line first");
  chk_test_ac_off: assert property ($rose(test_req_line) && low_reg >= 42 && low_reg <= 1198
    && fault_oe && dc_trip_oe && ac_trip_oe |-> ##[50:62] !ac_trip_oe)
    else $error("test did not release ac line");
  chk_host_pulse: assert property ($fell(test_req_oe) |-> req_reg == PULSE_CYC)
    else $error("test request low time wrong");
  chk_req_rest: assert property ($fell(test_req_oe) |=> !test_req_oe [*8])
    else $error("test request repeated too soon");
endmodule : rct_link_chk

// ==== residual_current_trip_outputs_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    samples_checked++; \
    if ((a) !== (e)) \
    begin \
      mismatches++; \
      $display("mismatch at %0t got %0h expected %0h", $time, (a), (e)); \
    end \
  end
module residual_current_trip_outputs_tb;
  import rct_pkg::*;
  logic               i_clock;
  logic               i_sys_rst;
  logic               i_sys_fault;
  logic               i_meas_valid;
  logic signed [15:0] i_dc_ua;
  logic        [15:0] i_ac_ua;
  logic               i_test_start;
  logic               o_relay_on;
  logic               o_error;
  logic               o_dc_trip;
  logic               o_ac_trip;
  logic               o_test_busy;
  logic               o_test_active;
  logic               o_test_active_b;
  logic        [15:0] o_offset_ua;
  logic        [15:0] o_offset_ua_b;
  int                 mismatches;
  int                 samples_checked;

  // Shortened timing; u_rct_sensor_end_b takes SIM_MIN_CYC, SIM_MAX_CYC and SIM_STEP_CYC and keeps the default PWM period; checker defaults match these
  localparam int unsigned SIM_MIN_CYC   = 40;
  localparam int unsigned SIM_MAX_CYC   = 1200;
  localparam int unsigned SIM_STEP_CYC  = 50;
  localparam int unsigned SIM_PWM_CYC   = 125;
  localparam int unsigned SIM_PULSE_CYC = 100;
  localparam int unsigned SIM_WAIT_CYC  = 200;

  rct_link_if link ();
  rct_link_if link_b ();

  rct_sensor_end #(.TEST_MIN_CYC(SIM_MIN_CYC), .TEST_MAX_CYC(SIM_MAX_CYC),
    .TEST_STEP_CYC(SIM_STEP_CYC), .PWM_PERIOD_CYC(SIM_PWM_CYC)) u_rct_sensor_end (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_sys_fault(i_sys_fault), .i_meas_valid(i_meas_valid), .i_dc_ua(i_dc_ua),
    .i_ac_ua(i_ac_ua), .link(link), .o_test_active(o_test_active), .o_offset_ua(o_offset_ua));
  rct_sensor_end #(.TEST_MIN_CYC(SIM_MIN_CYC), .TEST_MAX_CYC(SIM_MAX_CYC),
    .TEST_STEP_CYC(SIM_STEP_CYC)) u_rct_sensor_end_b (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_sys_fault(i_sys_fault), .i_meas_valid(i_meas_valid), .i_dc_ua(i_dc_ua),
    .i_ac_ua(i_ac_ua), .link(link_b), .o_test_active(o_test_active_b),
    .o_offset_ua(o_offset_ua_b));
  rct_ctrl_end #(.PULSE_CYC(SIM_PULSE_CYC), .WAIT_CYC(SIM_WAIT_CYC)) u_rct_ctrl_end (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_test_start(i_test_start), .o_relay_on(o_relay_on),
    .o_error(o_error), .o_dc_trip(o_dc_trip), .o_ac_trip(o_ac_trip),
    .o_test_busy(o_test_busy), .link(link));
  rct_link_chk u_rct_link_chk (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .fault_o(link.fault_o), .fault_oe(link.fault_oe),
    .dc_trip_o(link.dc_trip_o), .dc_trip_oe(link.dc_trip_oe), .ac_trip_o(link.ac_trip_o),
    .ac_trip_oe(link.ac_trip_oe), .pwm(link.pwm), .test_req_oe(link.test_req_oe),
    .fault_line(link.fault_line), .dc_trip_line(link.dc_trip_line),
    .ac_trip_line(link.ac_trip_line), .test_req_line(link.test_req_line));

  initial i_clock = 1'b0;
  always #5 i_clock = ~i_clock;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask : tick

  task automatic meas(input logic [15:0] dc, input logic [15:0] ac, input logic v, input int n);
    @(posedge i_clock);
    i_dc_ua      <= dc;
    i_ac_ua      <= ac;
    i_meas_valid <= v;
    tick(n);
    @(negedge i_clock);
  endtask : meas

  task automatic wait_st(input logic [2:0] mask, input logic [2:0] want, input int lim);
    int i;
    @(negedge i_clock);
    for (i = 0; i < lim && (({o_test_busy, link.ac_trip_line, link.dc_trip_line} & mask)
         !== want); i++)
      @(negedge i_clock);
    if (({o_test_busy, link.ac_trip_line, link.dc_trip_line} & mask) !== want)
    begin
      mismatches++;
      report_and_stop();
    end
  endtask : wait_st

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_selftest;
    wait_st(3'h4, 3'h0, 2000);
    @(posedge i_clock);
    i_test_start <= 1'b1;
    @(posedge i_clock);
    i_test_start <= 1'b0;
    wait_st(3'h4, 3'h4, 10);
    `CHK(o_relay_on, 1'b0)
    wait_st(3'h3, 3'h1, 200);
    tick(4);
    @(negedge i_clock);
    `CHK(o_error, 1'b0)
    `CHK(o_dc_trip, 1'b1)
    `CHK(o_test_active, 1'b1)
    wait_st(3'h3, 3'h3, 80);
    wait_st(3'h7, 3'h0, 400);
    `CHK(o_relay_on, 1'b1)
    `CHK(o_test_active, 1'b0)
    `CHK(o_offset_ua, 16'h0000)
  endtask : t_selftest

  task automatic t_dc;
    logic [15:0] dc[7] = '{16'h176F, 16'h1770, 16'h09C4, 16'h09C3, 16'hE891, 16'hE890, 16'h0};
    logic [6:0]  ex    = 7'h26;
    for (int i = 0; i < 7; i++)
    begin
      meas(dc[i], 16'h0000, 1'b1, 6);
      `CHK(link.dc_trip_line, ex[i])
      `CHK(o_dc_trip, ex[i])
      `CHK(link.ac_trip_line, 1'b0)
    end
    meas(16'h1B58, 16'h0000, 1'b0, 6);
    `CHK(link.dc_trip_line, 1'b0)
    meas(16'h0000, 16'h0000, 1'b1, 2);
    meas(16'h7530, 16'h0000, 1'b1, 1);
    `CHK(link.dc_trip_line, 1'b1)
    meas(16'h0000, 16'h0000, 1'b1, 2);
  endtask : t_dc

  task automatic t_ac;
    logic [15:0] ac[4] = '{16'h61A7, 16'h61A8, 16'h2710, 16'h270F};
    logic [3:0]  ex    = 4'h6;
    for (int i = 0; i < 4; i++)
    begin
      meas(16'h0000, ac[i], 1'b1, 6);
      `CHK(link.ac_trip_line, ex[i])
      `CHK(link.dc_trip_line, ex[i])
      `CHK(o_ac_trip, ex[i])
      `CHK(o_error, 1'b0)
    end
    meas(16'h0000, 16'h7530, 1'b1, 1);
    `CHK(link.ac_trip_line, 1'b1)
    meas(16'h0000, 16'h0000, 1'b1, 2);
  endtask : t_ac

  task automatic t_fault;
    @(posedge i_clock);
    i_sys_fault <= 1'b1;
    tick(6);
    @(negedge i_clock);
    `CHK(link.fault_line, 1'b1)
    `CHK({link.ac_trip_line, link.dc_trip_line}, 2'h3)
    `CHK(o_error, 1'b1)
    @(posedge i_clock);
    i_sys_fault <= 1'b0;
    tick(6);
    @(negedge i_clock);
    `CHK(link.fault_line, 1'b0)
    `CHK(o_relay_on, 1'b1)
  endtask : t_fault

  task automatic t_pwm;
    logic [15:0] dc[3] = '{16'h0000, 16'h1770, 16'h7530};
    logic [7:0]  hi[3] = '{8'h00, 8'h18, 8'h7C};
    logic [7:0]  n;
    for (int i = 0; i < 3; i++)
    begin
      meas(dc[i], 16'h0000, 1'b1, 300);
      n = 8'h00;
      repeat (125)
      begin
        @(negedge i_clock);
        if (link.pwm === 1'b1)
          n++;
      end
      `CHK(n, hi[i])
    end
    meas(16'h0000, 16'h0000, 1'b1, 6);
  endtask : t_pwm

  task automatic t_pulse_b;
    logic [10:0] len[4] = '{11'h01E, 11'h028, 11'h4B0, 11'h4B1};
    logic [15:0] dc[4]  = '{16'h0011, 16'h0123, 16'h0145, 16'h0167};
    logic [15:0] off[4] = '{16'h0000, 16'h0123, 16'h0145, 16'h0145};
    logic [3:0]  act    = 4'h6;
    for (int i = 0; i < 4; i++)
    begin
      meas(dc[i], 16'h0000, 1'b1, 2);
      @(posedge i_clock);
      link_b.test_req_oe <= 1'b1;
      tick(int'(len[i]));
      link_b.test_req_oe <= 1'b0;
      tick(10);
      @(negedge i_clock);
      `CHK(o_test_active_b, act[i])
      tick(200);
      @(negedge i_clock);
      `CHK(o_offset_ua_b, off[i])
    end
    meas(16'h18B4, 16'h0000, 1'b1, 6);
    `CHK(link_b.dc_trip_line, 1'b0)
    `CHK(link.dc_trip_line, 1'b1)
    meas(16'h0000, 16'h0000, 1'b1, 6);
  endtask : t_pulse_b

  initial
  begin
    #900000;
    mismatches++;
    report_and_stop();
  end

  initial
  begin
    mismatches         = 0;
    samples_checked    = 0;
    i_sys_rst          = 1'b1;
    i_sys_fault        = 1'b0;
    i_meas_valid       = 1'b0;
    i_dc_ua            = 16'h0000;
    i_ac_ua            = 16'h0000;
    i_test_start       = 1'b0;
    link_b.test_req_o  = 1'b0;
    link_b.test_req_oe = 1'b0;
    tick(5);
    i_sys_rst    <= 1'b0;
    i_meas_valid <= 1'b1;
    tick(3);
    t_selftest();
    t_dc();
    t_ac();
    t_fault();
    t_pwm();
    t_pulse_b();
    report_and_stop();
  end
endmodule : residual_current_trip_outputs_tb
